// File: design/fsps_consts.vh
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH
`define FSPS_MODE_CTRL_ADDR 12'hfa2
`define FSPS_PROTECT_ADDR 12'hfa1
`define FSPS_CMD_ADDR 12'hfa3
`define FSPS_BLOCK_ADDR 12'hfa4
`define FSPS_ADDR_LO_ADDR 12'hfa5
`define FSPS_ADDR_HI_ADDR 12'hfa6
`define FSPS_WDATA_ADDR 12'hfa7
`define FSPS_STATUS_ADDR 12'hfa8
`define FSPS_UNLOCK_KEY 8'ha5
`define FSPS_MODE_BIT 0
`define FSPS_CMD_VERIFY_BLOCK 8'h01
`define FSPS_CMD_VERIFY_BYTE 8'h02
`define FSPS_CMD_ERASE 8'h03
`define FSPS_CMD_BLANK 8'h04
`define FSPS_CMD_WRITE 8'h05
`define FSPS_CLK_MHZ 20
`define FSPS_T_VERIFY_BLOCK_US 6800
`define FSPS_T_VERIFY_BYTE_US 27
`define FSPS_T_ERASE_US 8500
`define FSPS_T_BLANK_US 480
`define FSPS_T_WRITE_US 150
`define FSPS_CYC_VERIFY_BYTE (`FSPS_T_VERIFY_BYTE_US * `FSPS_CLK_MHZ)
`define FSPS_CYC_BLANK (`FSPS_T_BLANK_US * `FSPS_CLK_MHZ)
`define FSPS_CYC_WRITE (`FSPS_T_WRITE_US * `FSPS_CLK_MHZ)
`define FSPS_CYC_VERIFY_BLOCK (`FSPS_T_VERIFY_BLOCK_US * `FSPS_CLK_MHZ)
`define FSPS_CYC_ERASE (`FSPS_T_ERASE_US * `FSPS_CLK_MHZ)
`endif

// File: design/fsps_sequencer.v
// What this block does
// - self-program mode entered only by key write then mode write; else unchanged
// - in self-program mode the stop instruction launches the preloaded flash command
// - the stop state is released automatically when the command completes
// - whole-block verify takes 6.8 ms
// - per-byte verify takes 27 us per byte
// - block erase erases the loaded block number, 8.5 ms per pass
// - blank check reports whether the loaded block is erased within 480 us
// - byte write programs the loaded byte at the loaded address in 150 us
// - cpu execution is suspended for the whole command
// - mode control register content is undefined after reset
// - written flash data is readable by ordinary cpu loads
// - commands run regardless of external programmer protection
`timescale 1ns/1ps
`include "fsps_consts.vh"
module fsps_sequencer #(
    parameter ADDR_W = 12,
    parameter BLOCK_BITS = 10,
    parameter T_VERIFY_BLOCK = `FSPS_CYC_VERIFY_BLOCK,
    parameter T_ERASE = `FSPS_CYC_ERASE
) (
    input wire clock_in,
    input wire rst_n_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [11:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    input wire cpu_halt_in,
    output wire cpu_stall_out,
    output reg cpu_wake_out,
    input wire [ADDR_W-1:0] cpu_rd_addr_in,
    output reg [7:0] cpu_rd_data_out,
    input wire protect_ext_in
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_DONE = 3'b100;
    localparam [23:0] C_VB = `FSPS_CYC_VERIFY_BYTE;
    localparam [23:0] C_BL = `FSPS_CYC_BLANK;
    localparam [23:0] C_WR = `FSPS_CYC_WRITE;
    localparam [23:0] C_VK = T_VERIFY_BLOCK;
    localparam [23:0] C_ER = T_ERASE;
    localparam NWORD = 1 << ADDR_W;

    reg [7:0] flash_mem [0:NWORD-1];
    reg [7:0] mode_ctrl_reg;
    reg armed_reg;
    reg [7:0] cmd_reg;
    reg [7:0] block_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [7:0] wdata_reg;
    reg [2:0] state_reg;
    reg [23:0] count_reg;
    reg result_reg;
    reg check_reg;
    reg [ADDR_W-1:0] scan_reg;
    wire self_mode = mode_ctrl_reg[`FSPS_MODE_BIT];
    wire [ADDR_W-1:0] blk_base = {block_reg[ADDR_W-BLOCK_BITS-1:0], {BLOCK_BITS{1'b0}}};
    reg [23:0] dur;

    // the wake cycle is skipped so the cpu can drop its halt before it is seen again
    wire launch = (state_reg == ST_IDLE) && cpu_halt_in && self_mode && !cpu_wake_out;
    // loads are refused while a command runs so it keeps its operands
    wire reg_wr_ok = reg_wr_in && (state_reg == ST_IDLE);
    wire key_write = reg_wr_ok && (reg_addr_in == `FSPS_PROTECT_ADDR) &&
        (reg_wdata_in == `FSPS_UNLOCK_KEY);

    // verify byte looks only at the loaded address, never at its neighbours
    wire byte_match = (flash_mem[addr_reg] == wdata_reg);
    wire cell_blank = (flash_mem[scan_reg] == 8'hff);
    wire scan_last = &scan_reg[BLOCK_BITS-1:0];
    wire count_last = (count_reg <= 24'h000001);
    wire [7:0] addr_hi_rd = {{(16-ADDR_W){1'b0}}, addr_reg[ADDR_W-1:8]};

    // an unknown command still ends after two cycles, so the cpu is never left stalled
    always @*
    begin
        case (cmd_reg)
            `FSPS_CMD_VERIFY_BLOCK: dur = C_VK;
            `FSPS_CMD_VERIFY_BYTE: dur = C_VB;
            `FSPS_CMD_ERASE: dur = C_ER;
            `FSPS_CMD_BLANK: dur = C_BL;
            `FSPS_CMD_WRITE: dur = C_WR;
            default: dur = 24'h000001;
        endcase
    end

    assign cpu_stall_out = (state_reg != ST_IDLE);

    // mode_ctrl_reg has no reset on purpose; the unlock arm and the other control registers are cleared
    always @(posedge clock_in)
    begin
        // writes during a command are dropped like every other register load
        if (reg_wr_ok && reg_addr_in == `FSPS_MODE_CTRL_ADDR && armed_reg)
            mode_ctrl_reg <= reg_wdata_in;
    end

    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            armed_reg <= 1'b0;
            cmd_reg <= 8'h00;
            block_reg <= 8'h00;
            addr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= 8'h00;
            state_reg <= ST_IDLE;
            count_reg <= 24'h000000;
            result_reg <= 1'b0;
            check_reg <= 1'b0;
            scan_reg <= {ADDR_W{1'b0}};
            cpu_wake_out <= 1'b0;
        end
        else
        begin
            cpu_wake_out <= 1'b0;
            if (reg_wr_ok)
            begin
                // any write other than the key disarms the sequence
                // only the write right after the key reaches the mode register
                armed_reg <= key_write;
                case (reg_addr_in)
                    `FSPS_CMD_ADDR: cmd_reg <= reg_wdata_in;
                    `FSPS_BLOCK_ADDR: block_reg <= reg_wdata_in;
                    `FSPS_ADDR_LO_ADDR: addr_reg[7:0] <= reg_wdata_in;
                    `FSPS_ADDR_HI_ADDR: addr_reg[ADDR_W-1:8] <= reg_wdata_in[ADDR_W-9:0];
                    `FSPS_WDATA_ADDR: wdata_reg <= reg_wdata_in;
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE:
                begin
                    // protect_ext_in deliberately not consulted
                    if (launch)
                    begin
                        state_reg <= ST_RUN;
                        // counts down to one, so the stall lasts the count plus one
                        count_reg <= dur;
                        check_reg <= 1'b1;
                        scan_reg <= blk_base;
                    end
                end
                ST_RUN:
                begin
                    if (cmd_reg == `FSPS_CMD_BLANK && !cell_blank)
                        check_reg <= 1'b0;
                    if (cmd_reg == `FSPS_CMD_VERIFY_BYTE && !byte_match)
                        check_reg <= 1'b0;
                    // the scan parks on the last cell of the block
                    if (!scan_last)
                        scan_reg <= scan_reg + 1'b1;
                    if (count_last)
                        state_reg <= ST_DONE;
                    else
                        count_reg <= count_reg - 24'h000001;
                end
                ST_DONE:
                begin
                    // the result becomes visible together with the wake pulse
                    result_reg <= check_reg;
                    cpu_wake_out <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // erase and write land on the completion cycle only
    genvar gi;
    generate
        for (gi = 0; gi < NWORD; gi = gi + 1)
        begin : g_cell
            // each cell knows its own address at the address width
            localparam [ADDR_W-1:0] CELL_ADDR = gi;
            // a write can only clear bits, as a real cell would
            always @(posedge clock_in)
            begin
                if (state_reg == ST_DONE && cmd_reg == `FSPS_CMD_ERASE &&
                    CELL_ADDR[ADDR_W-1:BLOCK_BITS] == block_reg[ADDR_W-BLOCK_BITS-1:0])
                    flash_mem[gi] <= 8'hff;
                else if (state_reg == ST_DONE && cmd_reg == `FSPS_CMD_WRITE &&
                    CELL_ADDR == addr_reg)
                    flash_mem[gi] <= flash_mem[gi] & wdata_reg;
            end
        end
    endgenerate

    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= 8'h00;
            cpu_rd_data_out <= 8'h00;
        end
        else
        begin
            // flash reads stay open during a command; the stalled cpu issues none
            cpu_rd_data_out <= flash_mem[cpu_rd_addr_in];
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    `FSPS_MODE_CTRL_ADDR: reg_rdata_out <= mode_ctrl_reg;
                    `FSPS_CMD_ADDR: reg_rdata_out <= cmd_reg;
                    `FSPS_BLOCK_ADDR: reg_rdata_out <= block_reg;
                    `FSPS_ADDR_LO_ADDR: reg_rdata_out <= addr_reg[7:0];
                    `FSPS_ADDR_HI_ADDR: reg_rdata_out <= addr_hi_rd;
                    `FSPS_WDATA_ADDR: reg_rdata_out <= wdata_reg;
                    `FSPS_STATUS_ADDR: reg_rdata_out <= {6'h00, cpu_stall_out, result_reg};
                    default: reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end
endmodule

// File: tb/fsps_properties.sv
`timescale 1ns/1ps
`include "fsps_consts.vh"
module fsps_properties #(
    parameter T_VERIFY_BLOCK = 50,
    parameter T_ERASE = 50
) (
    input wire clock_in,
    input wire rst_n_in,
    input wire reg_rd_in,
    input wire [11:0] reg_addr_in,
    input wire [7:0] reg_rdata_out,
    input wire cpu_halt_in,
    input wire cpu_stall_out,
    input wire cpu_wake_out
);
    int n;
    wire len_ok;
    function automatic bit near(input int a, input int b);
        return a == b || a == b + 1;
    endfunction
    // stall length must match one of the command durations
    assign len_ok = near(n, T_VERIFY_BLOCK) || near(n, `FSPS_CYC_VERIFY_BYTE) ||
        near(n, T_ERASE) || near(n, `FSPS_CYC_BLANK) || near(n, `FSPS_CYC_WRITE);
    always @(posedge clock_in)
    begin
        n <= (cpu_stall_out && rst_n_in) ? n + 1 : 0;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence launch;
        !cpu_stall_out ##1 cpu_stall_out;
    endsequence
    AST_LAUNCH_CAUSE: assert property (launch |-> $past(cpu_halt_in))
        else $error("stall began without halt");
    AST_STALL_MIN: assert property (launch |-> cpu_stall_out [*8])
        else $error("stall too short");
    AST_WAKE_END: assert property (cpu_wake_out |-> $past(cpu_stall_out) && !cpu_stall_out)
        else $error("wake not at end of stall");
    AST_FALL_WAKES: assert property ($fell(cpu_stall_out) |-> cpu_wake_out)
        else $error("stall ended without wake");
    AST_WAKE_ONCE: assert property (cpu_wake_out |=> !cpu_wake_out [*8])
        else $error("wake repeated");
    AST_STALL_MAX: assert property (cpu_stall_out |-> n <= `FSPS_CYC_BLANK + 1)
        else $error("stall too long");
    AST_DURATION: assert property (cpu_wake_out |-> len_ok)
        else $error("command duration wrong");
    AST_BUSY_IDLE: assert property (reg_rd_in && reg_addr_in == `FSPS_STATUS_ADDR
        && !cpu_stall_out && !cpu_halt_in |=> !reg_rdata_out[1])
        else $error("busy set while idle");
    AST_RDATA_HOLD: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
        else $error("read data changed without read");
endmodule
bind fsps_sequencer fsps_properties #(.T_VERIFY_BLOCK(T_VERIFY_BLOCK), .T_ERASE(T_ERASE))
    u_fsps_properties (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out), .cpu_halt_in(cpu_halt_in),
    .cpu_stall_out(cpu_stall_out), .cpu_wake_out(cpu_wake_out));

// File: tb/fsps_cpu_model.sv
`timescale 1ns/1ps
module fsps_cpu_model (
    input wire clock_in,
    input wire go_in,
    input wire wake_in,
    output reg halt_out,
    output reg wdt_clr_out
);
    reg go_q = 1'b0;
    initial halt_out = 1'b0;
    always @(posedge clock_in)
    begin
        go_q <= go_in;
        wdt_clr_out <= go_in && !go_q;
        if (wake_in || !go_in)
            halt_out <= 1'b0;
        else if (!go_q)
            halt_out <= 1'b1;
    end
endmodule

// File: tb/fsps_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "fsps_consts.vh"
module fsps_sequencer_tb_top;
    reg clock_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    reg [11:0] addr = 12'h000, fa = 12'h000;
    reg [7:0] wd = 8'h00;
    wire [7:0] rdata, fdata;
    wire halt, stall, wake;
    int num_errors = 0, comparisons = 0;
    fsps_sequencer #(.T_VERIFY_BLOCK(50), .T_ERASE(50)) u_fsps_sequencer (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_rdata_out(rdata), .cpu_halt_in(halt), .cpu_stall_out(stall),
        .cpu_wake_out(wake), .cpu_rd_addr_in(fa), .cpu_rd_data_out(fdata),
        .protect_ext_in(1'b1));
    fsps_cpu_model u_fsps_cpu_model (.clock_in(clock_in), .go_in(go), .wake_in(wake),
        .halt_out(halt), .wdt_clr_out());
    task chk(input string what, input logic [7:0] e, input logic [7:0] got);
        comparisons++;
        if (got !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task wr_reg(input [11:0] a, input [7:0] d);
        @(posedge clock_in);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask
    task rd_reg(input [11:0] a, input [7:0] e);
        @(posedge clock_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 chk("register", e, rdata);
    endtask
    task rd_flash(input [11:0] a, input [7:0] e);
        @(posedge clock_in);
        fa <= a;
        repeat (2) @(posedge clock_in);
        #1 chk("flash", e, fdata);
    endtask
    task enter(input [7:0] v);
        wr_reg(`FSPS_PROTECT_ADDR, `FSPS_UNLOCK_KEY);
        wr_reg(`FSPS_MODE_CTRL_ADDR, v);
    endtask
    task run(input [7:0] c);
        int i;
        wr_reg(`FSPS_CMD_ADDR, c);
        @(posedge clock_in);
        go <= 1'b1;
        for (i = 0; i < 12000 && wake !== 1'b1; i++)
        begin
            @(posedge clock_in);
            #1;
        end
        chk("wake", 8'h01, {7'h00, wake});
        @(posedge clock_in);
        go <= 1'b0;
    endtask
    task end_of_test;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end
    initial
    begin
        #(60000 * 50);
        num_errors++;
        end_of_test;
    end
    initial
    begin
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        enter(8'h00);
        rd_reg(`FSPS_MODE_CTRL_ADDR, 8'h00);
        @(posedge clock_in);
        go <= 1'b1;
        repeat (20) @(posedge clock_in);
        go <= 1'b0;
        #1 chk("stall", 8'h00, {7'h00, stall});
        wr_reg(`FSPS_PROTECT_ADDR, `FSPS_UNLOCK_KEY);
        wr_reg(`FSPS_CMD_ADDR, `FSPS_CMD_WRITE);
        wr_reg(`FSPS_MODE_CTRL_ADDR, 8'h01);
        rd_reg(`FSPS_MODE_CTRL_ADDR, 8'h00);
        enter(8'h01);
        rd_reg(`FSPS_MODE_CTRL_ADDR, 8'h01);
        wr_reg(`FSPS_BLOCK_ADDR, 8'h00);
        wr_reg(`FSPS_ADDR_LO_ADDR, 8'h00);
        wr_reg(`FSPS_ADDR_HI_ADDR, 8'h00);
        rd_reg(`FSPS_ADDR_HI_ADDR, 8'h00);
        repeat (2) run(`FSPS_CMD_ERASE);
        run(`FSPS_CMD_BLANK);
        rd_reg(`FSPS_STATUS_ADDR, 8'h01);
        wr_reg(`FSPS_ADDR_LO_ADDR, 8'h05);
        rd_reg(`FSPS_ADDR_LO_ADDR, 8'h05);
        wr_reg(`FSPS_WDATA_ADDR, 8'h3c);
        run(`FSPS_CMD_WRITE);
        rd_flash(12'h005, 8'h3c);
        rd_flash(12'h006, 8'hff);
        run(`FSPS_CMD_VERIFY_BYTE);
        rd_reg(`FSPS_STATUS_ADDR, 8'h01);
        wr_reg(`FSPS_WDATA_ADDR, 8'h3d);
        run(`FSPS_CMD_VERIFY_BYTE);
        rd_reg(`FSPS_STATUS_ADDR, 8'h00);
        run(`FSPS_CMD_VERIFY_BLOCK);
        rd_reg(`FSPS_STATUS_ADDR, 8'h01);
        run(`FSPS_CMD_BLANK);
        rd_reg(`FSPS_STATUS_ADDR, 8'h00);
        end_of_test;
    end
endmodule
